//--- gie_regs.vh
`ifndef GIE_REGS_VH
`define GIE_REGS_VH
`define GIE_NUM_GROUPS      12
`define GIE_GROUP_SIZE      8
`define GIE_NUM_CPU_INTS    16
`define GIE_GROUP_EN_RESET  8'h00
`define GIE_CPU_EN_RESET    16'h0000
`define GIE_ACK_ALL         12'hFFF
`define GIE_CPU_LINE_DLOG   14
`define GIE_CPU_LINE_RTOS   15
`endif

//--- gie_group.v
`timescale 1ns/1ps
`default_nettype none
`include "gie_regs.vh"
module gie_group #(
    parameter WIDTH = `GIE_GROUP_SIZE
) (
    // Clock and reset
    input  wire             i_sys_clk,
    input  wire             i_reset,
    // Sources and control
    input  wire [WIDTH-1:0] i_src,
    input  wire [WIDTH-1:0] i_enable,
    input  wire             i_take,
    input  wire             i_ack,
    // Status
    output reg  [WIDTH-1:0] o_pending,
    output reg              o_blocked,
    output wire             o_request,
    output reg  [2:0]       o_winner
);
    reg [WIDTH-1:0] winner_onehot;
    reg             found;
    integer         k;

    // Lowest index wins: position 1 is bit 0
    always @* begin
        winner_onehot = {WIDTH{1'b0}};
        o_winner      = 3'h0;
        found         = 1'b0;
        for (k = 0; k < WIDTH; k = k + 1) begin
            if (!found && o_pending[k] && i_enable[k]) begin // R2 R3
                found            = 1'b1;
                winner_onehot[k] = 1'b1;
                o_winner         = k[2:0];
            end
        end
    end

    assign o_request = found && !o_blocked; // R9

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_pend
            // A high source level beats the clear in the same cycle
            always @(posedge i_sys_clk or posedge i_reset) begin
                if (i_reset) begin
                    o_pending[g] <= 1'b0;
                end else if (i_src[g]) begin
                    o_pending[g] <= 1'b1; // R9
                end else if (i_take && winner_onehot[g]) begin
                    o_pending[g] <= 1'b0; // R9
                end
            end
        end
    endgenerate

    // Ack reopens the group; a take in the same cycle keeps it blocked
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_blocked <= 1'b0;
        end else if (i_take) begin
            o_blocked <= 1'b1; // R9
        end else if (i_ack) begin
            o_blocked <= 1'b0; // R8
        end
    end
endmodule // gie_group
`default_nettype wire

//--- gie_expander.v
// Operation
// R1: Each CPU line 1-12 fed by eight sources.
// R2: Per-group enable bits gate each source.
// R3: Within group, position one wins.
// R4: Lines 1-14, datalog, realtime-os are maskable.
// R5: Fixed hardware priority arbitrates CPU lines.
// R6: Line one highest, line two next.
// R7: Sixteen-bit CPU enable register masks lines.
// R8: Ack ones re-enable the matching groups.
// R9: Pending latched, cleared on take, group blocked.
`timescale 1ns/1ps
`default_nettype none
`include "gie_regs.vh"
module gie_expander #(
    parameter NGROUPS = `GIE_NUM_GROUPS,
    parameter GSIZE   = `GIE_GROUP_SIZE,
    parameter NCPU    = `GIE_NUM_CPU_INTS
) (
    // Clock and reset
    input  wire                     i_sys_clk,
    input  wire                     i_reset,
    // Peripheral sources, group g at bits [8g+7:8g]
    input  wire [NGROUPS*GSIZE-1:0] i_group_source_line,
    input  wire                     i_peripheral_interrupt_expander_en,
    // Non-expanded CPU lines 13..16 (13,14,datalog,realtime-os)
    input  wire [NCPU-NGROUPS-1:0]  i_direct_int,
    // Configuration
    input  wire [NGROUPS*GSIZE-1:0] i_group_enable_reg,
    input  wire [NCPU-1:0]          i_cpu_int_enable_reg,
    input  wire [NGROUPS-1:0]       i_group_ack_reg,
    input  wire                     i_group_ack_wr,
    // CPU side
    input  wire                     i_cpu_take,
    output reg                      o_cpu_irq,
    output reg  [3:0]               o_cpu_line,
    output reg  [2:0]               o_cpu_source,
    output reg  [NCPU-1:0]          o_cpu_flags,
    // Status
    output reg  [NGROUPS*GSIZE-1:0] o_pending,
    output reg  [NGROUPS-1:0]       o_group_blocked
);
    wire [NGROUPS*GSIZE-1:0] pend_w;
    wire [NGROUPS-1:0]       blocked_w;
    wire [NGROUPS-1:0]       greq;
    wire [NGROUPS*3-1:0]     gwin;
    reg  [NGROUPS-1:0]       gtake;
    reg  [NCPU-1:0]          raw_line;
    reg  [NCPU-1:0]          masked;
    reg                      next_irq;
    reg  [3:0]               next_line;
    reg  [2:0]               next_src;
    reg                      found;
    integer                  j;

    genvar g;
    generate
        for (g = 0; g < NGROUPS; g = g + 1) begin : gen_grp
            gie_group #(.WIDTH(GSIZE)) u_group (
                .i_sys_clk (i_sys_clk),
                .i_reset   (i_reset),
                .i_src     (i_group_source_line[g*GSIZE +: GSIZE] &
                            {GSIZE{i_peripheral_interrupt_expander_en}}), // R1
                .i_enable  (i_group_enable_reg[g*GSIZE +: GSIZE]), // R2
                .i_take    (gtake[g]),
                .i_ack     (i_group_ack_wr & i_group_ack_reg[g]), // R8
                .o_pending (pend_w[g*GSIZE +: GSIZE]),
                .o_blocked (blocked_w[g]),
                .o_request (greq[g]),
                .o_winner  (gwin[g*3 +: 3])
            );
        end
    endgenerate

    // Line one is index zero, so the lowest set bit wins
    always @* begin
        raw_line  = {i_direct_int, greq & {NGROUPS{i_peripheral_interrupt_expander_en}}}; // R1
        masked    = raw_line & i_cpu_int_enable_reg; // R4 R7
        next_irq  = 1'b0;
        next_line = 4'h0;
        next_src  = 3'h0;
        found     = 1'b0;
        for (j = 0; j < NCPU; j = j + 1) begin
            if (!found && masked[j]) begin // R5 R6
                found     = 1'b1;
                next_irq  = 1'b1;
                next_line = j[3:0];
                next_src  = (j < NGROUPS) ? gwin[j*3 +: 3] : 3'h0;
            end
        end
        // Take applies to the line presented on the registered outputs
        gtake = {NGROUPS{1'b0}};
        if (i_cpu_take && o_cpu_irq && o_cpu_line < NGROUPS) begin
            gtake[o_cpu_line] = 1'b1; // R9
        end
    end

    // Registered outputs lag by one cycle; the take carries the shown vector
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_cpu_irq       <= 1'b0;
            o_cpu_line      <= 4'h0;
            o_cpu_source    <= 3'h0;
            o_cpu_flags     <= `GIE_CPU_EN_RESET;
            o_pending       <= {NGROUPS*GSIZE{1'b0}};
            o_group_blocked <= {NGROUPS{1'b0}};
        end else begin
            o_cpu_irq       <= next_irq & ~i_cpu_take;
            o_cpu_line      <= next_line;
            o_cpu_source    <= next_src;
            o_cpu_flags     <= raw_line;
            o_pending       <= pend_w;
            o_group_blocked <= blocked_w;
        end
    end
endmodule // gie_expander
`default_nettype wire

//--- gie_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gie_checker #(parameter NGROUPS = 12, parameter GSIZE = 8, parameter NCPU = 16) (
    input wire logic i_sys_clk, i_reset, i_cpu_take, i_group_ack_wr,
    input wire logic i_peripheral_interrupt_expander_en, o_cpu_irq,
    input wire logic [3:0] o_cpu_line,
    input wire logic [2:0] o_cpu_source,
    input wire logic [NCPU-1:0] o_cpu_flags, i_cpu_int_enable_reg,
    input wire logic [NGROUPS-1:0] o_group_blocked, i_group_ack_reg,
    input wire logic [NGROUPS*GSIZE-1:0] o_pending, i_group_source_line, i_group_enable_reg
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_take; i_cpu_take && o_cpu_irq && o_cpu_line < 4'hC; endsequence
    sequence s_no_ack; !i_group_ack_wr [*2]; endsequence
    a_line_winner: assert property (o_cpu_irq |-> ((o_cpu_flags & $past(i_cpu_int_enable_reg))
        & ((17'h2 << o_cpu_line) - 17'h1)) == (17'h1 << o_cpu_line)) else $error("wrong line");
    a_masked_quiet: assert property (!(|(o_cpu_flags & $past(i_cpu_int_enable_reg)))
        |-> !o_cpu_irq) else $error("irq with all lines masked");
    a_source_order: assert property (o_cpu_irq && o_cpu_line < 4'hC |->
        (((o_pending & $past(i_group_enable_reg)) >> (GSIZE * o_cpu_line))
        & ((2 << o_cpu_source) - 1)) == (1 << o_cpu_source)) else $error("wrong source");
    a_pend_cause: assert property ((o_pending & ~$past(o_pending) & ~($past(i_group_source_line)
        | $past(i_group_source_line, 2))) == '0) else $error("pending without source");
    a_take_drops: assert property (i_cpu_take && o_cpu_irq |=> !o_cpu_irq)
        else $error("irq stands after take");
    a_take_blocks: assert property (s_take ##0 s_no_ack |-> ##1
        o_group_blocked[$past(o_cpu_line, 2)]) else $error("group not blocked");
    a_ack_reopens: assert property (i_group_ack_wr && !i_cpu_take ##1 !i_cpu_take |=>
        (o_group_blocked & $past(i_group_ack_reg, 2)) == '0) else $error("group not reopened");
    a_expander_off: assert property (!i_peripheral_interrupt_expander_en [*2] |->
        !(o_cpu_irq && o_cpu_line < 4'hC)) else $error("group line while expander off");
endmodule // gie_checker
bind gie_expander gie_checker #(.NGROUPS(NGROUPS), .GSIZE(GSIZE), .NCPU(NCPU)) gie_checker_inst (
    .i_sys_clk, .i_reset, .i_cpu_take, .i_group_ack_wr, .i_peripheral_interrupt_expander_en,
    .o_cpu_irq, .o_cpu_line, .o_cpu_source, .o_cpu_flags, .i_cpu_int_enable_reg, .o_group_blocked,
    .i_group_ack_reg, .o_pending, .i_group_source_line, .i_group_enable_reg);
`default_nettype wire

//--- gie_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module gie_cpu_model (
    input wire logic i_sys_clk, i_reset, i_irq, i_slow,
    input wire logic [3:0] i_line,
    output logic o_take, o_ack_wr,
    output logic [11:0] o_ack
);
    logic [2:0] cnt, sh;
    logic [3:0] taken;
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            {o_take, o_ack_wr, o_ack, cnt, sh, taken} <= '0;
        end else begin
            // Slow mode lets the request stand a few cycles first
            cnt <= (i_irq && !o_take) ? cnt + 3'h1 : 3'h0;
            o_take <= i_irq && !o_take && cnt >= (i_slow ? 3'h4 : 3'h0);
            sh <= {sh[1:0], o_take && i_irq};
            if (o_take && i_irq) taken <= i_line;
            o_ack_wr <= sh[1];
            // Unqualified ack bits toggle so stale values never look valid
            o_ack <= sh[1] ? 12'h1 << taken : ~o_ack;
        end
    end
endmodule // gie_cpu_model
`default_nettype wire

//--- gie_expander_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gie_expander_tb_top;
    logic i_sys_clk = 1'b0, i_reset = 1'b1, en = 1'b1, slow = 1'b0, irq, take, ack_wr;
    logic [95:0] src = 96'h0, gen = {96{1'b1}};
    logic [15:0] cen = 16'hFFFF;
    logic [11:0] ack;
    logic [3:0] dir = 4'h0, line;
    logic [2:0] source;
    logic [6:0] q[$];
    int err_count = 0, n_compared = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    gie_expander gie_expander_inst (.i_sys_clk, .i_reset, .i_group_source_line(src),
        .i_peripheral_interrupt_expander_en(en), .i_direct_int(dir), .i_group_enable_reg(gen),
        .i_cpu_int_enable_reg(cen), .i_group_ack_reg(ack), .i_group_ack_wr(ack_wr),
        .i_cpu_take(take), .o_cpu_irq(irq), .o_cpu_line(line), .o_cpu_source(source),
        .o_cpu_flags(), .o_pending(), .o_group_blocked());
    gie_cpu_model gie_cpu_model_inst (.i_sys_clk, .i_reset, .i_irq(irq), .i_slow(slow),
        .i_line(line), .o_take(take), .o_ack_wr(ack_wr), .o_ack(ack));
    always @(posedge i_sys_clk) if (take && irq) q.push_back({line, source});
    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [6:0] got, input logic [6:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic fire(input logic [95:0] v);
        @(posedge i_sys_clk) #1 src = v;
        @(posedge i_sys_clk) #1 src = 96'h0;
    endtask
    task automatic take_is(input logic [6:0] exp, input logic [6:0] m);
        for (int n = 0; n < 60 && q.size() == 0; n++) @(posedge i_sys_clk) #1;
        if (q.size() == 0) begin
            err_count++;
            final_report();
        end else cmp(q.pop_front() & m, exp);
    endtask
    task automatic none;
        repeat (30) @(posedge i_sys_clk);
        #1 cmp(7'(q.size()), 7'h0);
    endtask
    initial begin
        repeat (20) @(posedge i_sys_clk);
        #1 i_reset = 1'b0;
        fire((96'h1 << 4) | (96'h1 << 8) | (96'h1 << 95));
        take_is(7'h04, 7'h7F);
        take_is(7'h08, 7'h7F);
        take_is(7'h5F, 7'h7F);
        @(posedge i_sys_clk) #1 slow = 1'b1;
        fire(96'h48 << 40);
        take_is(7'h2B, 7'h7F);
        take_is(7'h2E, 7'h7F);
        @(posedge i_sys_clk) #1 cen = 16'h7FFB;
        fire(96'h2 << 16);
        dir = 4'h8;
        none();
        @(posedge i_sys_clk) #1 cen = 16'h7FFF;
        take_is(7'h11, 7'h7F);
        @(posedge i_sys_clk) #1 cen = 16'hFFFF;
        take_is(7'h78, 7'h78);
        @(posedge i_sys_clk) #1 dir = 4'h0;
        repeat (10) @(posedge i_sys_clk);
        q.delete();
        en = 1'b0;
        fire(96'h1 << 32);
        @(posedge i_sys_clk) #1 en = 1'b1;
        none();
        gen[49] = 1'b0;
        fire(96'h2 << 48);
        none();
        final_report();
    end
endmodule // gie_expander_tb_top
`default_nettype wire
